// ===== design/rtc_pin_ctrl.sv
// Pin control of an SPI clock chip: SPI slave, alarm or square wave pin,
// 32 kHz gating, supervisor reset pin and oscillator halt flag.
// Assumes pins and analog levels are asynchronous; alarm_match is on pclk.
`timescale 1ns/10ps
`default_nettype none
module rtc_pin_ctrl
   import rtc_pin_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int RST_CYCLES      = RST_CYC,
   parameter int REC_CYCLES      = REC_CYC,
   parameter int OSF_CYCLES      = OSF_CYC
)
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   // SPI pins
   input  wire spi_in_t     spi_in,
   output logic             dout,
   output logic             dout_oe,
   // Alarm or square wave pin, open drain
   output logic             irq_sqw_o,
   output logic             irq_sqw_oe,
   // Reset pin, open drain
   input  wire logic        rst_pin_i,
   output logic             rst_pin_o,
   output logic             rst_pin_oe,
   // Oscillator and supply sense
   input  wire logic        clk32k_in,
   input  wire logic [3:0]  sq_taps,
   input  wire logic        alarm_match,
   input  wire logic        osc_running,
   input  wire logic        power_fail,
   output logic             out32k
);

   if (DEBOUNCE_CYCLES < 1 || RST_CYCLES < 1 || REC_CYCLES < 1 || OSF_CYCLES < 1)
   begin : g_bad_timing
      $error("timing counts must be at least one cycle");
   end

   // Two flop synchronisers for every asynchronous input
   localparam int NSYNC = 11;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] meta_r;
   logic [NSYNC-1:0] sync_r;
   assign async_in = {spi_in.cs_n, spi_in.sclk, spi_in.din, rst_pin_i, clk32k_in,
                      osc_running, power_fail, sq_taps};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               meta_r[gi] <= 1'b1;
               sync_r[gi] <= 1'b1;
            end
            else
            begin
               meta_r[gi] <= async_in[gi];
               sync_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

   wire       cs_n_s   = sync_r[10];
   wire       sclk_s   = sync_r[9];
   wire       din_s    = sync_r[8];
   wire       rst_s    = sync_r[7];
   wire       clk32k_s = sync_r[6];
   wire       osc_run_s = sync_r[5];
   wire       pfail_s  = sync_r[4];
   wire [3:0] taps_s   = sync_r[3:0];

   // Registers
   ctrl_t            ctrl_r;
   logic [EV_W-1:0]  status_r;
   logic [EV_W-1:0]  mask_r;
   logic [7:0]       txd_r;
   logic [7:0]       rxd_r;
   logic             halt_flag_r;
   logic             first_pu_r;

   // APB decode
   wire setup_ph  = psel & ~penable;
   wire access_ok = psel & penable & pready;
   wire wr_en     = access_ok & pwrite & ~pslverr;
   wire sel_ctrl  = (paddr == CTRL_OFS);
   wire sel_stat  = (paddr == STATUS_OFS);
   wire sel_mask  = (paddr == MASK_OFS);
   wire sel_txd   = (paddr == TXD_OFS);
   wire sel_rxd   = (paddr == RXD_OFS);
   wire sel_state = (paddr == STATE_OFS);
   wire mapped    = sel_ctrl | sel_stat | sel_mask | sel_txd | sel_rxd | sel_state;

   logic [31:0] rd_mux;
   rst_state_t  rst_st_r;
   logic        is_read_r;

   assign rd_mux = sel_ctrl  ? {26'h0, ctrl_r} :
                   sel_stat  ? {28'h0, status_r} :
                   sel_mask  ? {28'h0, mask_r} :
                   sel_txd   ? {24'h0, txd_r} :
                   sel_rxd   ? {24'h0, rxd_r} :
                   sel_state ? {24'h0, is_read_r, ~cs_n_s, rst_pin_oe, pfail_s,
                                osc_run_s, first_pu_r, irq_sqw_oe, halt_flag_r} :
                   32'h0;

   // Read data is captured in the setup cycle so pready and prdata are flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= setup_ph;
         pslverr <= setup_ph & ~mapped;
         if (setup_ph)
            prdata <= pwrite ? 32'h0 : rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= CTRL_RESET;
         mask_r <= 4'h0;
         txd_r  <= 8'h0;
      end
      else if (wr_en)
      begin
         if (sel_ctrl)
            ctrl_r <= pwdata[5:0];
         if (sel_mask)
            mask_r <= pwdata[EV_W-1:0];
         if (sel_txd)
            txd_r <= pwdata[7:0];
      end
   end

   // SPI slave, sampled by pclk
   logic       cs_prev_r;
   logic       sclk_prev_r;
   logic       cpol_r;
   logic [2:0] bit_cnt_r;
   logic       first_byte_r;
   logic [6:0] shin_r;
   logic [7:0] shout_r;
   logic       byte_ev_r;

   wire cs_fall   = cs_prev_r & ~cs_n_s;
   wire sclk_edge = ~cs_n_s & ~cs_fall & (sclk_s ^ sclk_prev_r);
   wire lead_edge = sclk_edge & (sclk_prev_r == cpol_r);
   wire trail_edge = sclk_edge & (sclk_s == cpol_r);
   wire byte_done = trail_edge & (bit_cnt_r == 3'd7);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cs_prev_r    <= 1'b1;
         sclk_prev_r  <= 1'b1;
         cpol_r       <= 1'b1;
         bit_cnt_r    <= 3'd0;
         first_byte_r <= 1'b1;
         is_read_r    <= 1'b0;
         shin_r       <= 7'h0;
         shout_r      <= 8'h0;
         rxd_r        <= 8'h0;
         byte_ev_r    <= 1'b0;
         dout         <= 1'b0;
         dout_oe      <= 1'b0;
      end
      else
      begin
         cs_prev_r   <= cs_n_s;
         sclk_prev_r <= sclk_s;
         byte_ev_r   <= byte_done & ~first_byte_r;
         if (cs_n_s)
         begin
            bit_cnt_r    <= 3'd0;
            first_byte_r <= 1'b1;
            is_read_r    <= 1'b0;
            dout_oe      <= 1'b0;
         end
         else
         begin
            if (cs_fall)
               cpol_r <= sclk_s;
            if (trail_edge)
            begin
               shin_r    <= {shin_r[5:0], din_s};
               bit_cnt_r <= bit_cnt_r + 3'd1;
            end
            if (byte_done)
            begin
               first_byte_r <= 1'b0;
               shout_r      <= txd_r;
               if (first_byte_r)
                  is_read_r <= ~shin_r[6];
               else
                  rxd_r <= {shin_r, din_s};
            end
            if (lead_edge & is_read_r)
            begin
               dout    <= shout_r[7];
               shout_r <= {shout_r[6:0], 1'b0};
            end
            dout_oe <= is_read_r & ~first_byte_r;
         end
      end
   end

   // Alarm or square wave pin and 32 kHz gate
   wire sq_level = taps_s[ctrl_r.rate_select];
   wire irq_pull = ctrl_r.interrupt_select ? alarm_match : ~sq_level;
   wire gate32k  = ctrl_r.osc_output_enable & ctrl_r.battery_osc_output_enable;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_sqw_o  <= 1'b0;
         irq_sqw_oe <= 1'b0;
         out32k     <= 1'b0;
      end
      else
      begin
         irq_sqw_o  <= 1'b0;
         irq_sqw_oe <= irq_pull;
         out32k     <= clk32k_s & gate32k;
      end
   end

   // Oscillator stop detection; saturates so the flag sets only once
   logic [31:0] osf_cnt_r;
   wire osf_hit = ~osc_run_s & (osf_cnt_r == OSF_CYCLES - 1);
   wire halt_clr = wr_en & sel_state & pwdata[0];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osf_cnt_r   <= 32'h0;
         halt_flag_r <= 1'b0;
      end
      else
      begin
         if (osc_run_s)
            osf_cnt_r <= 32'h0;
         else if (osf_cnt_r < OSF_CYCLES)
            osf_cnt_r <= osf_cnt_r + 32'h1;
         if (osf_hit)
            halt_flag_r <= 1'b1;
         else if (halt_clr)
            halt_flag_r <= 1'b0;
      end
   end

   // Reset pin supervisor
   logic [31:0] rst_cnt_r;
   logic        rst_prev_r;
   wire bypass    = first_pu_r | ~osc_run_s;
   wire rec_skip  = bypass | ctrl_r.osc_stop_on_battery;
   wire btn_fall  = rst_prev_r & ~rst_s;
   wire cnt_zero  = (rst_cnt_r == 32'h0);
   wire pfail_ev  = pfail_s & ~rst_st_r[1];
   wire button_ev = (rst_st_r == RS_IDLE) & btn_fall & ~pfail_s;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_st_r   <= RS_PFAIL;
         rst_cnt_r  <= 32'h0;
         rst_prev_r <= 1'b1;
         first_pu_r <= 1'b1;
         rst_pin_o  <= 1'b0;
         rst_pin_oe <= 1'b1;
      end
      else
      begin
         rst_prev_r <= rst_s;
         rst_pin_o  <= 1'b0;
         if (!cnt_zero)
            rst_cnt_r <= rst_cnt_r - 32'h1;
         if (pfail_s)
            rst_st_r <= RS_PFAIL;
         else
            case (rst_st_r)
               RS_PFAIL:
               begin
                  first_pu_r <= 1'b0;
                  if (rec_skip)
                     rst_st_r <= RS_IDLE;
                  else
                  begin
                     rst_st_r  <= RS_HOLD;
                     rst_cnt_r <= REC_CYCLES - 1;
                  end
               end
               RS_IDLE:
                  if (btn_fall)
                  begin
                     rst_st_r  <= RS_DEBNC;
                     rst_cnt_r <= DEBOUNCE_CYCLES - 1;
                  end
               RS_DEBNC:
                  if (cnt_zero)
                     rst_st_r <= RS_WREL;
               RS_WREL:
                  if (rst_s)
                  begin
                     rst_st_r  <= bypass ? RS_IDLE : RS_HOLD;
                     rst_cnt_r <= RST_CYCLES - 1;
                  end
               RS_HOLD:
                  if (cnt_zero)
                     rst_st_r <= RS_IDLE;
               default:
                  rst_st_r <= RS_PFAIL;
            endcase
         // Released while waiting so the button level can be watched
         rst_pin_oe <= pfail_s | ~(rst_st_r == RS_IDLE || rst_st_r == RS_WREL) |
                       (rst_st_r == RS_IDLE & btn_fall);
      end
   end

   // Sticky events; a read clears only what it returned, so a new set survives
   logic [EV_W-1:0] ev_set;
   assign ev_set = {pfail_ev, button_ev, byte_ev_r, osf_hit};
   wire stat_rd = access_ok & ~pwrite & sel_stat;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_r <= 4'h0;
         irq      <= 1'b0;
      end
      else
      begin
         status_r <= (status_r & ~(stat_rd ? prdata[EV_W-1:0] : 4'h0)) | ev_set;
         irq      <= |(status_r & mask_r);
      end
   end

endmodule
`default_nettype wire

// ===== design/rtc_pin_pkg.sv
// Shared constants and types of the clock chip pin control block.
// Assumes a 20 MHz pclk and an APB register port of 32-bit words.
package rtc_pin_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS   = 8'h08;
   localparam logic [7:0] TXD_OFS    = 8'h0c;
   localparam logic [7:0] RXD_OFS    = 8'h10;
   localparam logic [7:0] STATE_OFS  = 8'h14;

   // Control field positions
   localparam int CTRL_INT_SEL = 0;
   localparam int CTRL_RS_LOW  = 1;
   localparam int CTRL_RS_HIGH = 2;
   localparam int CTRL_OSC_EN  = 3;
   localparam int CTRL_BB_EN   = 4;
   localparam int CTRL_OSC_STOP_ON_BATTERY    = 5;
   localparam logic [5:0] CTRL_RESET = 6'h01;

   // Event bits of status and mask
   localparam int EV_HALT   = 0;
   localparam int EV_BYTE   = 1;
   localparam int EV_BUTTON = 2;
   localparam int EV_PFAIL  = 3;
   localparam int EV_W      = 4;

   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_DEBOUNCE_MS = 250;
   localparam int T_RST_MS      = 250;
   localparam int T_REC_MS      = 125;
   localparam int T_OSF_MS      = 100;
   localparam int DEBOUNCE_CYC  = T_DEBOUNCE_MS * (1000000 / CLK_PERIOD_NS);
   localparam int RST_CYC       = T_RST_MS * (1000000 / CLK_PERIOD_NS);
   localparam int REC_CYC       = T_REC_MS * (1000000 / CLK_PERIOD_NS);
   localparam int OSF_CYC       = T_OSF_MS * (1000000 / CLK_PERIOD_NS);

   typedef enum logic [4:0] {
      RS_IDLE  = 5'b00001,
      RS_PFAIL = 5'b00010,
      RS_DEBNC = 5'b00100,
      RS_WREL  = 5'b01000,
      RS_HOLD  = 5'b10000
   } rst_state_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } spi_in_t;

   typedef struct packed {
      logic       osc_stop_on_battery;
      logic       battery_osc_output_enable;
      logic       osc_output_enable;
      logic [1:0] rate_select;
      logic       interrupt_select;
   } ctrl_t;

endpackage

// ===== tb/rtc_pin_ctrl_assertions.sv
// Port-level checker of the clock chip pin control block.
// Assumes binding to rtc_pin_ctrl; it sees that module's ports only.
`timescale 1ns/10ps
`default_nettype none
module rtc_pin_ctrl_assertions
   import rtc_pin_pkg::*;
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins
   input wire spi_in_t     spi_in,
   input wire logic        dout_oe,
   input wire logic        irq_sqw_o,
   input wire logic        rst_pin_o,
   input wire logic        rst_pin_oe,
   input wire logic        power_fail
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_desel;
      spi_in.cs_n [*5];
   endsequence
   a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
      else $error("pready not a single pulse after setup");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_data_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refused access returned data");
   a_desel_quiet: assert property (s_desel |-> !dout_oe)
      else $error("data output driven while deselected");
   a_oe_rise_sel: assert property ($rose(dout_oe) |-> !spi_in.cs_n)
      else $error("data output enabled without select");
   a_pfail_pulls: assert property (power_fail [*6] |-> rst_pin_oe)
      else $error("reset pin free during power fail");
   a_button_hold: assert property ($rose(rst_pin_oe) && !power_fail |-> rst_pin_oe [*8])
      else $error("reset pin pulse too short");
   a_drain_low: assert property (!irq_sqw_o && !rst_pin_o)
      else $error("open drain pin driven high");
endmodule
bind rtc_pin_ctrl rtc_pin_ctrl_assertions i_rtc_pin_ctrl_assertions (.*);
`default_nettype wire

// ===== tb/spi_host_model.sv
// SPI host model for the block's select, clock and data pins.
// Assumes 20 MHz pclk; a link clock half period is four pclk cycles.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
   import rtc_pin_pkg::*;
(
   // Clock
   input wire logic  pclk,
   // Pins
   input wire logic  dout,
   input wire logic  dout_oe,
   output var spi_in_t spi
);
   logic saw_oe;
   initial spi = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
   task automatic half();
      repeat (4) @(posedge pclk);
   endtask
   // Clock stands still between frames; dout is sampled late to ride out its sync delay
   task automatic xfer(input logic cpol, input int nbits, input logic [23:0] tx, output logic [23:0] rx);
      rx = 24'h0;
      saw_oe = 1'b0;
      spi.sclk <= cpol;
      half();
      spi.cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++)
      begin
         half();
         saw_oe |= dout_oe;
         if (i > 0) rx = {rx[22:0], dout_oe & dout};
         // Data moves with the leading edge so it stands when the trailing edge samples it
         spi.sclk <= ~cpol;
         spi.din <= tx[23 - i];
         half();
         spi.sclk <= cpol;
      end
      half();
      saw_oe |= dout_oe;
      rx = {rx[22:0], dout_oe & dout};
      spi.cs_n <= 1'b1;
      spi.din <= ~spi.din;
      half();
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_rtc_pin_ctrl.sv
// Self-checking bench of the pin control block with an SPI host model.
// Assumes short hold counts of N cycles and a pull-up on the reset pin.
`timescale 1ns/10ps
`default_nettype none
module tb_rtc_pin_ctrl
   import rtc_pin_pkg::*;
;
   localparam int N = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   logic [23:0] rx;
   logic [3:0]  sq_taps;
   logic        dout, dout_oe, irq_sqw_o, irq_sqw_oe, btn, rst_pin_i, rst_pin_o, rst_pin_oe;
   logic        clk32k_in, alarm_match, osc_running, power_fail, out32k;
   spi_in_t     spi;
   int          n_fail, comparisons, cyc_n;
   assign rst_pin_i = !(btn || rst_pin_oe);
   rtc_pin_ctrl #(.DEBOUNCE_CYCLES(N), .RST_CYCLES(N), .REC_CYCLES(N), .OSF_CYCLES(N)) i_rtc_pin_ctrl (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
      .spi_in(spi), .dout, .dout_oe, .irq_sqw_o, .irq_sqw_oe, .rst_pin_i, .rst_pin_o, .rst_pin_oe,
      .clk32k_in, .sq_taps, .alarm_match, .osc_running, .power_fail, .out32k);
   spi_host_model i_spi_host_model (.pclk, .dout, .dout_oe, .spi);
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic close_out();
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // A whole run takes about 1250 cycles
   always @(posedge pclk)
   begin
      cyc_n++;
      if (cyc_n == 20000)
      begin
         n_fail++;
         close_out();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      d = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic t_reset();
      cyc(6);
      check("rst pin", rst_pin_oe, 0);
      apb(1'b0, CTRL_OFS, 0);
      check("ctrl", d, 32'h1);
      check("irq pin", irq_sqw_oe, 0);
      apb(1'b0, 8'h3c, 0);
      check("unmapped", {d[30:0], er}, 32'h1);
      apb(1'b0, STATUS_OFS, 0);
   endtask
   task automatic t_pins();
      clk32k_in <= 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, CTRL_OFS, 32'(m << 3));
         cyc(5);
         check("out32k", out32k, 32'(m == 3));
      end
      clk32k_in <= 1'b0;
      cyc(5);
      check("out32k low", out32k, 0);
      for (int r = 0; r < 4; r++)
      begin
         apb(1'b1, CTRL_OFS, 32'(r << 1));
         sq_taps <= ~(4'h1 << r);
         cyc(5);
         check("sqw low", irq_sqw_oe, 1);
         sq_taps <= 4'h1 << r;
         cyc(5);
         check("sqw high", irq_sqw_oe, 0);
      end
      apb(1'b1, CTRL_OFS, 32'h1);
      alarm_match <= 1'b1;
      cyc(5);
      check("alarm", irq_sqw_oe, 1);
      alarm_match <= 1'b0;
      cyc(5);
      check("no alarm", irq_sqw_oe, 0);
   endtask
   task automatic t_spi();
      apb(1'b1, TXD_OFS, 32'ha5);
      apb(1'b1, MASK_OFS, 32'h1 << EV_BYTE);
      for (int c = 0; c < 2; c++)
      begin
         i_spi_host_model.xfer(c[0], 24, 24'h050000, rx);
         check("read bytes", rx[15:0], 16'ha5a5);
         cyc(3);
         check("irq set", irq, 1);
         apb(1'b0, STATUS_OFS, 0);
         cyc(3);
         check("irq clear", irq, 0);
      end
      i_spi_host_model.xfer(1'b1, 24, 24'h853c96, rx);
      check("write oe", i_spi_host_model.saw_oe, 0);
      apb(1'b0, RXD_OFS, 0);
      check("rxd", d, 32'h96);
      i_spi_host_model.xfer(1'b0, 5, 24'hff0000, rx);
      i_spi_host_model.xfer(1'b0, 16, 24'h855a00, rx);
      apb(1'b0, RXD_OFS, 0);
      check("rxd partial", d, 32'h5a);
      apb(1'b1, MASK_OFS, 0);
   endtask
   task automatic t_supply();
      for (int k = 0; k < 3; k++)
      begin
         apb(1'b1, CTRL_OFS, k == 1 ? 32'h21 : 32'h1);
         osc_running <= (k != 2);
         power_fail <= 1'b1;
         cyc(10);
         check("pfail", rst_pin_oe, 1);
         power_fail <= 1'b0;
         cyc(10);
         check("recovery", rst_pin_oe, 32'(k == 0));
         cyc(N + 10);
         check("released", rst_pin_oe, 0);
      end
      osc_running <= 1'b1;
      btn <= 1'b1;
      cyc(10);
      check("debounce", rst_pin_oe, 1);
      cyc(N + 10);
      check("await", rst_pin_oe, 0);
      btn <= 1'b0;
      cyc(10);
      check("hold", rst_pin_oe, 1);
      cyc(N + 10);
      check("done", rst_pin_oe, 0);
      apb(1'b0, STATUS_OFS, 0);
      check("button ev", d[EV_BUTTON], 1);
   endtask
   task automatic t_halt();
      apb(1'b1, STATE_OFS, 32'h1);
      osc_running <= 1'b0;
      cyc(N - 8);
      apb(1'b0, STATE_OFS, 0);
      check("halt early", d[0], 0);
      cyc(15);
      apb(1'b0, STATE_OFS, 0);
      check("halt set", d[0], 1);
      check("masked irq", irq, 0);
      osc_running <= 1'b1;
      apb(1'b1, STATE_OFS, 32'h1);
      apb(1'b0, STATE_OFS, 0);
      check("halt clear", d[0], 0);
   endtask
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, btn, clk32k_in, alarm_match, power_fail} = '0;
      {n_fail, comparisons, cyc_n} = '0;
      sq_taps = 4'hf;
      osc_running = 1'b1;
      cyc(4);
      check("reset pin", rst_pin_oe, 1);
      presetn <= 1'b1;
      t_reset();
      t_pins();
      t_spi();
      t_supply();
      t_halt();
      close_out();
   end
endmodule
`default_nettype wire
